// file: pkg/omsm_pkg.sv
// Package with mode codes, SPI frame layout and timing constants of the mode state machine
package omsm_pkg;
   // =====================================================
   // Mode field encoding as written over SPI
   localparam logic [1:0] OMSM_FLD_NORMAL = 2'h0;
   localparam logic [1:0] OMSM_FLD_SLEEP = 2'h1;
   localparam logic [1:0] OMSM_FLD_STOP = 2'h2;
   localparam logic [1:0] OMSM_FLD_RESET = 2'h3;
   localparam logic [1:0] OMSM_FLD_RST_VAL = 2'h0;
   // =====================================================
   // SPI frame layout
   localparam int OMSM_FRAME_BITS = 16;
   localparam logic [4:0] OMSM_FRAME_LAST = 5'h0F;
   localparam int OMSM_WR_BIT = 7;
   localparam int OMSM_ADDR_MSB = 6;
   localparam int OMSM_ADDR_LSB = 0;
   localparam int OMSM_MODE_MSB = 15;
   localparam int OMSM_MODE_LSB = 14;
   localparam logic [6:0] OMSM_MODE_ADDR = 7'h01;
   // =====================================================
   // Timing
   localparam int OMSM_CLK_MHZ = 250;
   localparam int OMSM_RD_TIME_US = 10;
   localparam int OMSM_RD_CYC = OMSM_RD_TIME_US * OMSM_CLK_MHZ;
   localparam int OMSM_LW_TIME_MS = 200;
   localparam int OMSM_LW_CYC = OMSM_LW_TIME_MS * 1000 * OMSM_CLK_MHZ;
   // =====================================================
   // One-hot operating modes
   typedef enum logic [5:0] {
      OMSM_INIT = 6'h01,
      OMSM_NORMAL = 6'h02,
      OMSM_STOP = 6'h04,
      OMSM_SLEEP = 6'h08,
      OMSM_RESTART = 6'h10,
      OMSM_FAILSAFE = 6'h20
   } omsm_state_e;
endpackage

// file: rtl/omsm_top.sv
// Operating-mode state machine with SPI slave and watchdog of the supply companion chip
`timescale 1ns/1ps
module omsm_top
   import omsm_pkg::*;
#(
   parameter int RD_CYC = omsm_pkg::OMSM_RD_CYC,
   parameter int LW_CYC = omsm_pkg::OMSM_LW_CYC,
   parameter int WDOG_CYC = omsm_pkg::OMSM_LW_CYC
)
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic spi_csn_i,
   input wire logic spi_sck_i,
   input wire logic spi_sdi_i,
   output logic spi_sdo_o,
   input wire logic wake_can_i,
   input wire logic wake_inputs_i,
   input wire logic supply_uv_i,
   input wire logic overtemp_i,
   input wire logic test_n_i,
   input wire logic cfg_strap_i,
   output logic main_regulator_output_o,
   output logic mcu_reset_n_o,
   output logic int_n_o,
   output logic dev_mode_o,
   output logic [1:0] op_mode_field_o,
   output logic [5:0] mode_o
);
   import omsm_pkg::*;

   // =====================================================
   // SPI slave, mode 0, sampled on SCK rising edge
   logic sck_q;
   logic csn_q;
   logic [15:0] shift_q;
   logic [4:0] bit_cnt_q;
   logic frame_done;
   logic [15:0] frame;
   logic sck_rise;
   logic sck_fall;
   logic [15:0] tx_q;

   assign sck_rise = spi_sck_i & ~sck_q;
   assign sck_fall = ~spi_sck_i & sck_q;
   assign frame = shift_q;
   // A frame ends when chip select rises after exactly 16 bits
   assign frame_done = spi_csn_i & ~csn_q & (bit_cnt_q == 5'(OMSM_FRAME_BITS));

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         sck_q <= 1'b0;
         csn_q <= 1'b1;
      end
      else
      begin
         sck_q <= spi_sck_i;
         csn_q <= spi_csn_i;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         shift_q <= 16'h0000;
         bit_cnt_q <= 5'h00;
      end
      else if (spi_csn_i)
      begin
         bit_cnt_q <= 5'h00;
      end
      else if (sck_rise)
      begin
         shift_q <= {shift_q[14:0], spi_sdi_i};
         // Saturates one past a full frame so longer frames are refused
         if (bit_cnt_q <= 5'(OMSM_FRAME_BITS))
         begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
      end
   end

   // Readback frame: current mode field in the top bits
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         tx_q <= 16'h0000;
      end
      else if (spi_csn_i)
      begin
         tx_q <= {op_mode_field_o, 6'h00, dev_mode_o, mode_o, 1'b0};
      end
      else if (sck_fall)
      begin
         tx_q <= {tx_q[14:0], 1'b0};
      end
   end
   assign spi_sdo_o = spi_csn_i ? 1'b0 : tx_q[15];

   // Decoded frame kinds
   logic mode_wr;
   logic [1:0] mode_req;
   assign mode_wr = frame_done & frame[OMSM_WR_BIT] &
                    (frame[OMSM_ADDR_MSB:OMSM_ADDR_LSB] == OMSM_MODE_ADDR);
   assign mode_req = frame[OMSM_MODE_MSB:OMSM_MODE_LSB];

   // =====================================================
   // Watchdog: any valid frame counts as trigger
   omsm_state_e st_q;
   logic [31:0] wdog_cnt_q;
   logic wdog_fail;
   logic [31:0] wdog_limit;
   logic wdog_run;

   assign wdog_limit = (st_q == OMSM_INIT) ? 32'(LW_CYC) : 32'(WDOG_CYC);
   assign wdog_run = (st_q == OMSM_INIT) | (st_q == OMSM_NORMAL);
   assign wdog_fail = wdog_run & ~dev_mode_o & (wdog_cnt_q >= wdog_limit - 32'h1);

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         wdog_cnt_q <= 32'h0;
      end
      else if (dev_mode_o || !wdog_run || frame_done || wdog_fail)
      begin
         wdog_cnt_q <= 32'h0;
      end
      else
      begin
         wdog_cnt_q <= wdog_cnt_q + 32'h1;
      end
   end

   // =====================================================
   // Strap capture while in init mode
   logic dev_q;
   logic cfg_q;
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         dev_q <= 1'b0;
         cfg_q <= 1'b0;
      end
      else if (st_q == OMSM_INIT)
      begin
         dev_q <= ~test_n_i;
         cfg_q <= cfg_strap_i;
      end
   end
   assign dev_mode_o = dev_q;

   // =====================================================
   // Operating mode state machine
   logic wake;
   logic [31:0] rd_cnt_q;
   logic rd_done;
   assign wake = wake_can_i | wake_inputs_i;
   assign rd_done = (rd_cnt_q >= 32'(RD_CYC) - 32'h1);

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= OMSM_INIT;
      end
      else
      begin
         case (st_q)
            OMSM_INIT:
            begin
               // Wake events are not looked at here
               if (wdog_fail)
               begin
                  st_q <= OMSM_RESTART;
               end
               else if (frame_done)
               begin
                  st_q <= OMSM_NORMAL;
               end
            end
            OMSM_NORMAL, OMSM_STOP:
            begin
               if (wdog_fail)
               begin
                  st_q <= cfg_q ? OMSM_RESTART : OMSM_FAILSAFE;
               end
               else if (supply_uv_i)
               begin
                  st_q <= OMSM_RESTART;
               end
               else if (mode_wr)
               begin
                  case (mode_req)
                     OMSM_FLD_NORMAL: st_q <= OMSM_NORMAL;
                     OMSM_FLD_SLEEP: st_q <= OMSM_SLEEP;
                     OMSM_FLD_STOP: st_q <= OMSM_STOP;
                     OMSM_FLD_RESET: st_q <= OMSM_INIT;
                     default: st_q <= st_q;
                  endcase
               end
               else if (st_q == OMSM_STOP && wake)
               begin
                  st_q <= OMSM_NORMAL;
               end
            end
            OMSM_SLEEP:
            begin
               if (wake)
               begin
                  st_q <= OMSM_RESTART;
               end
            end
            OMSM_RESTART:
            begin
               if (rd_done && !supply_uv_i)
               begin
                  st_q <= OMSM_NORMAL;
               end
            end
            OMSM_FAILSAFE:
            begin
               if (wake || !overtemp_i)
               begin
                  st_q <= OMSM_RESTART;
               end
            end
            default: st_q <= OMSM_INIT;
         endcase
      end
   end

   // Reset delay counter runs only while the failure has cleared
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         rd_cnt_q <= 32'h0;
      end
      else if (st_q != OMSM_RESTART || supply_uv_i)
      begin
         rd_cnt_q <= 32'h0;
      end
      else if (!rd_done)
      begin
         rd_cnt_q <= rd_cnt_q + 32'h1;
      end
   end

   // =====================================================
   // Mode field readback
   logic [1:0] fld_q;
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         fld_q <= OMSM_FLD_RST_VAL;
      end
      else if (st_q == OMSM_RESTART)
      begin
         fld_q <= OMSM_FLD_NORMAL;
      end
      else if (st_q == OMSM_STOP && wake && !mode_wr)
      begin
         fld_q <= OMSM_FLD_NORMAL;
      end
      else if (mode_wr && (st_q == OMSM_NORMAL || st_q == OMSM_STOP) && !wdog_fail && !supply_uv_i)
      begin
         fld_q <= (mode_req == OMSM_FLD_RESET) ? OMSM_FLD_NORMAL : mode_req;
      end
   end
   assign op_mode_field_o = fld_q;

   // =====================================================
   // Outputs
   logic int_q;
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         int_q <= 1'b0;
      end
      else
      begin
         int_q <= (st_q == OMSM_NORMAL) & wake;
      end
   end
   assign int_n_o = ~int_q;
   assign main_regulator_output_o = ~((st_q == OMSM_SLEEP) | (st_q == OMSM_FAILSAFE));
   assign mcu_reset_n_o = ~((st_q == OMSM_RESTART) | (st_q == OMSM_INIT) & ~frame_done);
   assign mode_o = st_q;
endmodule

// file: verification/omsm_props.sv
// Checker of the operating-mode state machine
`timescale 1ns/1ps
module omsm_props
   import omsm_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic wake_can_i,
   input wire logic wake_inputs_i,
   input wire logic overtemp_i,
   input wire logic supply_uv_i,
   input wire logic main_regulator_output_o,
   input wire logic mcu_reset_n_o,
   input wire logic int_n_o,
   input wire logic dev_mode_o,
   input wire logic [1:0] op_mode_field_o,
   input wire logic [5:0] mode_o
);
   // ==========
   // Properties
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic wk = wake_can_i | wake_inputs_i;
   AST_STOP_ON: assert property (mode_o == OMSM_STOP |-> main_regulator_output_o)
      else $error("regulator off in stop");
   AST_SLEEP_OFF: assert property (mode_o == OMSM_SLEEP |-> !main_regulator_output_o)
      else $error("regulator on in sleep");
   AST_FS_OFF: assert property (mode_o == OMSM_FAILSAFE |-> !main_regulator_output_o)
      else $error("regulator on in fail-safe");
   AST_RST_HOLD: assert property (mode_o == OMSM_RESTART |-> !mcu_reset_n_o)
      else $error("host not held in restart");
   AST_RST_MIN: assert property ($rose(mode_o == OMSM_RESTART) |-> (mode_o == OMSM_RESTART)[*8])
      else $error("restart left too early");
   AST_FIELD_CLR: assert property ((mode_o == OMSM_RESTART)[*3] |-> op_mode_field_o == 2'h0)
      else $error("field kept in restart");
   AST_WAKE_INT: assert property (mode_o == OMSM_NORMAL && wk |=> !int_n_o && mode_o == OMSM_NORMAL)
      else $error("wake in normal mishandled");
   AST_INIT_WAKE: assert property (mode_o == OMSM_INIT && wk |=> int_n_o)
      else $error("wake in init raised interrupt");
   AST_FS_STAY: assert property (mode_o == OMSM_FAILSAFE && !wk && overtemp_i |=> mode_o == OMSM_FAILSAFE)
      else $error("fail-safe left early");
   AST_DEV_WDOG: assert property (dev_mode_o && mode_o == OMSM_NORMAL |=> mode_o != OMSM_RESTART && mode_o != OMSM_FAILSAFE)
      else $error("watchdog ran in development mode");
   AST_UV_RST: assert property ((mode_o == OMSM_NORMAL || mode_o == OMSM_STOP) && supply_uv_i |=> mode_o == OMSM_RESTART || mode_o == OMSM_FAILSAFE)
      else $error("undervoltage did not force restart");
   AST_UV_HOLD: assert property (mode_o == OMSM_RESTART && supply_uv_i |=> mode_o == OMSM_RESTART)
      else $error("restart left while undervoltage present");
   cover property (mode_o == OMSM_FAILSAFE);
   cover property (mode_o == OMSM_SLEEP);
   cover property (dev_mode_o);
endmodule
bind omsm_top omsm_props u_props (.ref_clk_i, .rst_n_i, .wake_can_i, .wake_inputs_i, .overtemp_i, .supply_uv_i,
   .main_regulator_output_o, .mcu_reset_n_o, .int_n_o, .dev_mode_o, .op_mode_field_o, .mode_o);

// file: verification/omsm_host.sv
// Host controller model acting as SPI master
`timescale 1ns/1ps
module omsm_host
(
   input wire logic clk_i,
   input wire logic sdo_i,
   output logic csn_o,
   output logic sck_o,
   output logic sdi_o
);
   // ==========
   // Frame driver
   // Readback word shifted in during the last frame
   logic [15:0] rx;
   initial
   begin
      rx = 16'h0000;
      csn_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
   // Sends the n leading bits of w, MSB first
   task automatic xfer(input logic [15:0] w, input int n);
      repeat (2) @(posedge clk_i);
      csn_o <= 1'b0;
      for (int i = 15; i > 15 - n; i--)
      begin
         sdi_o <= w[i];
         repeat (2) @(posedge clk_i);
         sck_o <= 1'b1;
         rx = {rx[14:0], sdo_i};
         repeat (2) @(posedge clk_i);
         sck_o <= 1'b0;
      end
      repeat (2) @(posedge clk_i);
      csn_o <= 1'b1;
      sdi_o <= ~sdi_o;
      repeat (2) @(posedge clk_i);
   endtask
endmodule

// file: verification/tb_top.sv
// Self-checking testbench of the operating-mode state machine
`timescale 1ns/1ps
module tb_top;
   import omsm_pkg::*;
   localparam int RD = 20;
   localparam int WDOG = 300;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic csn, sck, sdi, sdo, reg_on, mrst_n, int_n, dev;
   logic uv = 1'b0;
   logic wk_can = 1'b0;
   logic wk_in = 1'b0;
   logic ot = 1'b0;
   logic test_n = 1'b1;
   logic strap = 1'b0;
   logic [1:0] fld;
   logic [5:0] mode;
   int n_errors = 0;
   int checked = 0;
   always #2 clk = ~clk;
   omsm_top #(.RD_CYC(RD), .LW_CYC(WDOG), .WDOG_CYC(WDOG)) u_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
      .spi_csn_i(csn), .spi_sck_i(sck), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .wake_can_i(wk_can),
      .wake_inputs_i(wk_in), .supply_uv_i(uv), .overtemp_i(ot), .test_n_i(test_n),
      .cfg_strap_i(strap), .main_regulator_output_o(reg_on), .mcu_reset_n_o(mrst_n),
      .int_n_o(int_n), .dev_mode_o(dev), .op_mode_field_o(fld), .mode_o(mode));
   omsm_host u_host (.clk_i(clk), .sdo_i(sdo), .csn_o(csn), .sck_o(sck), .sdi_o(sdi));
   // ==========
   // Helpers
   task automatic cmp(input logic [5:0] got, input logic [5:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cb(input logic got, input logic exp);
      cmp({5'h0, got}, {5'h0, exp});
   endtask
   // Waits up to lim cycles for mode m, sampling between edges
   task automatic wm(input logic [5:0] m, input int lim);
      @(negedge clk);
      repeat (lim)
         if (mode !== m)
            @(negedge clk);
      cmp(mode, m);
   endtask
   function automatic logic [15:0] wr(input logic [1:0] m);
      return {m, 6'h00, 1'b1, OMSM_MODE_ADDR};
   endfunction
   // ==========
   // Scenarios
   task automatic t_init;
      wm(OMSM_INIT, 1);
      @(posedge clk);
      wk_can <= 1'b1;
      repeat (3) @(negedge clk);
      cb(int_n, 1'b1);
      @(posedge clk);
      wk_can <= 1'b0;
      u_host.xfer(16'hFFFF, 15);
      wm(OMSM_INIT, 1);
      u_host.xfer(16'hFFFF, 16);
      wm(OMSM_NORMAL, 4);
      cb(mrst_n, 1'b1);
   endtask
   task automatic t_modes;
      u_host.xfer(wr(OMSM_FLD_STOP), 16);
      wm(OMSM_STOP, 4);
      cb(reg_on, 1'b1);
      cmp({4'h0, fld}, {4'h0, OMSM_FLD_STOP});
      u_host.xfer(16'h0001, 16);
      cmp({4'h0, u_host.rx[15:14]}, {4'h0, OMSM_FLD_STOP});
      cb(u_host.rx[7], 1'b0);
      cmp(u_host.rx[6:1], OMSM_STOP);
      cmp(mode, OMSM_STOP);
      u_host.xfer(wr(OMSM_FLD_NORMAL), 16);
      wm(OMSM_NORMAL, 4);
      cmp({4'h0, fld}, {4'h0, OMSM_FLD_NORMAL});
      u_host.xfer(wr(OMSM_FLD_STOP), 16);
      wm(OMSM_STOP, 4);
      @(posedge clk);
      wk_in <= 1'b1;
      wm(OMSM_NORMAL, 4);
      wm(OMSM_NORMAL, 2);
      cb(int_n, 1'b0);
      @(posedge clk);
      wk_in <= 1'b0;
      u_host.xfer(wr(OMSM_FLD_SLEEP), 16);
      wm(OMSM_SLEEP, 4);
      cb(reg_on, 1'b0);
      @(posedge clk);
      wk_can <= 1'b1;
      wm(OMSM_RESTART, 4);
      cb(mrst_n, 1'b0);
      @(posedge clk);
      wk_can <= 1'b0;
      repeat (RD - 8) @(negedge clk);
      cmp({4'h0, fld}, 6'h00);
      cmp(mode, OMSM_RESTART);
      wm(OMSM_NORMAL, 12);
   endtask
   task automatic t_fs;
      @(posedge clk);
      ot <= 1'b1;
      wm(OMSM_FAILSAFE, WDOG + 10);
      cb(reg_on, 1'b0);
      repeat (20) @(negedge clk);
      cmp(mode, OMSM_FAILSAFE);
      @(posedge clk);
      ot <= 1'b0;
      wm(OMSM_RESTART, 4);
      wm(OMSM_NORMAL, RD + 4);
      cmp({4'h0, fld}, 6'h00);
      @(posedge clk);
      uv <= 1'b1;
      wm(OMSM_RESTART, 4);
      cb(mrst_n, 1'b0);
      repeat (RD + 10) @(negedge clk);
      cmp(mode, OMSM_RESTART);
      @(posedge clk);
      uv <= 1'b0;
      wm(OMSM_NORMAL, RD + 4);
   endtask
   task automatic t_dev;
      @(posedge clk);
      test_n <= 1'b0;
      strap <= 1'b1;
      u_host.xfer(wr(OMSM_FLD_RESET), 16);
      wm(OMSM_INIT, 4);
      u_host.xfer(16'h0000, 16);
      wm(OMSM_NORMAL, 4);
      cb(dev, 1'b1);
      repeat (WDOG + 50) @(negedge clk);
      cmp(mode, OMSM_NORMAL);
      @(posedge clk);
      test_n <= 1'b1;
      u_host.xfer(wr(OMSM_FLD_RESET), 16);
      wm(OMSM_INIT, 4);
      wm(OMSM_RESTART, WDOG + 10);
      wm(OMSM_NORMAL, RD + 4);
      wm(OMSM_RESTART, WDOG + 10);
   endtask
   // ==========
   // Run control
   task automatic conclude;
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      conclude();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_init();
      t_modes();
      t_fs();
      t_dev();
      conclude();
   end
endmodule
